/* File: result_regs_pkg.sv */
package result_regs_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets on the management bus)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_LEGACY_RESULT_PORTS_3_4 = 8'h36;
    localparam logic [7:0] OFS_PORT1_CURRENT_LOW = 8'h40;
    localparam logic [7:0] OFS_PORT1_CURRENT_HIGH = 8'h41;
    localparam logic [7:0] OFS_PORT1_VOLTAGE_LOW = 8'h42;
    localparam logic [7:0] OFS_PORT1_VOLTAGE_HIGH = 8'h43;
    localparam logic [7:0] OFS_PORT2_CURRENT_LOW = 8'h44;
    localparam logic [7:0] OFS_PORT2_CURRENT_HIGH = 8'h45;
    localparam logic [7:0] OFS_PORT2_VOLTAGE_LOW = 8'h46;
    localparam logic [7:0] OFS_PORT2_VOLTAGE_HIGH = 8'h47;
    localparam logic [7:0] OFS_PORT3_CURRENT_LOW = 8'h48;
    localparam logic [7:0] OFS_PORT3_CURRENT_HIGH = 8'h49;
    localparam logic [7:0] OFS_SUPPLY_VOLTAGE_LOW = 8'h50;
    localparam logic [7:0] OFS_SUPPLY_VOLTAGE_HIGH = 8'h51;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int FOURTH_PORT_CODE_LSB = 4;
    localparam int THIRD_PORT_CODE_LSB = 0;
    localparam int CODE_W = 4;
    localparam int COUNT_W = 9;
    localparam int LOW_BIT_POS = 0;
    localparam int NUM_CHANNELS = 6;
    localparam int CHAN_W = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_LEGACY_CODE = 4'h0;
    localparam logic [8:0] RST_COUNT = 9'h000;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

    // ------------------------------------------------------------------
    // legacy detection outcome codes
    // ------------------------------------------------------------------
    localparam logic [3:0] LEG_NOT_RUN = 4'h0;
    localparam logic [3:0] LEG_VALID = 4'h1;
    localparam logic [3:0] LEG_NO_DISCHARGE = 4'h2;
    localparam logic [3:0] LEG_FIRST_OVER = 4'h4;
    localparam logic [3:0] LEG_SECOND_OVER = 4'h5;
    localparam logic [3:0] LEG_DELTA_LOW = 4'h6;

    // ------------------------------------------------------------------
    // converter channel numbers, one per result pair
    // ------------------------------------------------------------------
    localparam logic [2:0] CH_PORT1_CURRENT = 3'h0;
    localparam logic [2:0] CH_PORT1_VOLTAGE = 3'h1;
    localparam logic [2:0] CH_PORT2_CURRENT = 3'h2;
    localparam logic [2:0] CH_PORT2_VOLTAGE = 3'h3;
    localparam logic [2:0] CH_PORT3_CURRENT = 3'h4;
    localparam logic [2:0] CH_SUPPLY_VOLTAGE = 3'h5;

endpackage

/* File: port_telemetry_result_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE_01 - port 4 legacy outcome sits in bits 7:4 of register 36h.
// RULE_02 - port 3 legacy outcome sits in bits 3:0; both nibbles reset to zero.
// RULE_03 - code 0000 means not run; 0001 means valid capacitance, 5 to 100 uF.
// RULE_04 - code 0010 means load could not be discharged to 2.4 V.
// RULE_05 - 0100 first measurement above 18.5 V; 0101 second above it.
// RULE_06 - code 0110 means the two measurements differ by under 0.5 V.
// RULE_07 - port 1 current is 9 bits; its lsb is bit 0 of 40h, reset 0.
// RULE_08 - upper eight bits of port 1 current fill 41h, reset all zeros.
// RULE_09 - current counts are unsigned; current is 2.4 mA per count minus 10 mA.
// RULE_10 - port 1 pin voltage: lsb in 42h bit 0, upper eight bits in 43h.
// RULE_11 - output voltage is 0.15 V times supply count minus pin count.
// RULE_12 - port 2 current uses the same split across 44h and 45h.
// RULE_13 - port 2 pin voltage uses the same split across 46h and 47h.
// RULE_14 - port 3 current uses the same split across 48h and 49h.
// RULE_15 - all result registers are read-only; host writes change nothing.
// RULE_16 - supply voltage is a 9-bit count in 50h and 51h, 0.15 V per count.
// RULE_17 - both halves of a pair come from one conversion.
// RULE_18 - undefined legacy codes are never reported.
module port_telemetry_result_regs (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_rd_en,
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    output logic o_wr_ignored,
    input wire logic i_third_port_legacy_valid,
    input wire logic [3:0] i_third_port_legacy_code,
    input wire logic i_fourth_port_legacy_valid,
    input wire logic [3:0] i_fourth_port_legacy_code,
    output logic o_legacy_reject,
    input wire logic i_adc_valid,
    input wire logic [2:0] i_adc_chan,
    input wire logic [8:0] i_adc_count
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // true only for the outcome codes the detector is allowed to report
    function automatic logic legacy_code_ok(input logic [3:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            result_regs_pkg::LEG_NOT_RUN,
            result_regs_pkg::LEG_VALID,
            result_regs_pkg::LEG_NO_DISCHARGE,
            result_regs_pkg::LEG_FIRST_OVER,
            result_regs_pkg::LEG_SECOND_OVER,
            result_regs_pkg::LEG_DELTA_LOW: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // maps an offset onto a result pair: {hit, high half, channel}
    function automatic logic [4:0] decode_pair(input logic [7:0] addr);
        logic [4:0] d;
        d = 5'h00;
        case (addr)
            result_regs_pkg::OFS_PORT1_CURRENT_LOW: d = {2'b10, result_regs_pkg::CH_PORT1_CURRENT};
            result_regs_pkg::OFS_PORT1_CURRENT_HIGH: d = {2'b11, result_regs_pkg::CH_PORT1_CURRENT};
            result_regs_pkg::OFS_PORT1_VOLTAGE_LOW: d = {2'b10, result_regs_pkg::CH_PORT1_VOLTAGE};
            result_regs_pkg::OFS_PORT1_VOLTAGE_HIGH: d = {2'b11, result_regs_pkg::CH_PORT1_VOLTAGE};
            result_regs_pkg::OFS_PORT2_CURRENT_LOW: d = {2'b10, result_regs_pkg::CH_PORT2_CURRENT};
            result_regs_pkg::OFS_PORT2_CURRENT_HIGH: d = {2'b11, result_regs_pkg::CH_PORT2_CURRENT};
            result_regs_pkg::OFS_PORT2_VOLTAGE_LOW: d = {2'b10, result_regs_pkg::CH_PORT2_VOLTAGE};
            result_regs_pkg::OFS_PORT2_VOLTAGE_HIGH: d = {2'b11, result_regs_pkg::CH_PORT2_VOLTAGE};
            result_regs_pkg::OFS_PORT3_CURRENT_LOW: d = {2'b10, result_regs_pkg::CH_PORT3_CURRENT};
            result_regs_pkg::OFS_PORT3_CURRENT_HIGH: d = {2'b11, result_regs_pkg::CH_PORT3_CURRENT};
            result_regs_pkg::OFS_SUPPLY_VOLTAGE_LOW: d = {2'b10, result_regs_pkg::CH_SUPPLY_VOLTAGE};
            result_regs_pkg::OFS_SUPPLY_VOLTAGE_HIGH: d = {2'b11, result_regs_pkg::CH_SUPPLY_VOLTAGE};
            default: d = 5'h00;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [3:0] third_port_legacy_code_r;
    logic [3:0] fourth_port_legacy_code_r;
    logic [8:0] count_r [result_regs_pkg::NUM_CHANNELS];
    logic [7:0] high_hold_r;
    logic [2:0] hold_chan_r;
    logic hold_armed_r;
    logic [4:0] rd_dec;
    logic [4:0] wr_dec;
    logic rd_hit;
    logic rd_high;
    logic [2:0] rd_chan;
    logic [7:0] rd_data_nxt;
    logic [8:0] rd_count;
    logic adc_chan_ok;

    assign rd_dec = decode_pair(i_rd_addr);
    assign wr_dec = decode_pair(i_wr_addr);
    assign rd_hit = rd_dec[4];
    assign rd_high = rd_dec[3];
    assign rd_chan = rd_dec[2:0];
    assign rd_count = count_r[rd_chan];
    // channel 6 and 7 do not exist; samples aimed there are dropped
    assign adc_chan_ok = (i_adc_chan <= result_regs_pkg::CH_SUPPLY_VOLTAGE);

    // ------------------------------------------------------------------
    // legacy detection outcome nibbles
    // ------------------------------------------------------------------

    // an illegal code keeps the previous outcome rather than leaking garbage
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            third_port_legacy_code_r <= result_regs_pkg::RST_LEGACY_CODE; // [RULE_02]
        end else if (i_third_port_legacy_valid
                     && legacy_code_ok(i_third_port_legacy_code)) begin // [RULE_18]
            third_port_legacy_code_r <= i_third_port_legacy_code; // [RULE_03] [RULE_04]
        end
    end

    // port 4 nibble, same filtering as port 3
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            fourth_port_legacy_code_r <= result_regs_pkg::RST_LEGACY_CODE; // [RULE_02]
        end else if (i_fourth_port_legacy_valid
                     && legacy_code_ok(i_fourth_port_legacy_code)) begin // [RULE_18]
            fourth_port_legacy_code_r <= i_fourth_port_legacy_code; // [RULE_05] [RULE_06]
        end
    end

    // flags a dropped outcome so the detector side can notice its own fault
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_legacy_reject <= 1'b0;
        end else begin
            o_legacy_reject <=
                (i_third_port_legacy_valid && !legacy_code_ok(i_third_port_legacy_code))
                || (i_fourth_port_legacy_valid
                    && !legacy_code_ok(i_fourth_port_legacy_code)); // [RULE_18]
        end
    end

    // ------------------------------------------------------------------
    // converter results
    // ------------------------------------------------------------------

    // one write moves all nine bits, so low and high halves always agree;
    // counts are stored raw, scaling is left to host software
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            for (int i = 0; i < result_regs_pkg::NUM_CHANNELS; i++) begin
                count_r[i] <= result_regs_pkg::RST_COUNT; // [RULE_07] [RULE_08]
            end
        end else if (i_adc_valid && adc_chan_ok) begin
            count_r[i_adc_chan] <= i_adc_count; // [RULE_17] [RULE_09] [RULE_16]
        end
    end

    // ------------------------------------------------------------------
    // pair coherence across two serial reads
    // ------------------------------------------------------------------

    // reading a low half snapshots the high half of the same sample, so a
    // conversion landing between the two reads cannot split the pair; the
    // cost is that a high read without a low read first shows live data
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            high_hold_r <= result_regs_pkg::RST_READ_DATA;
            hold_chan_r <= result_regs_pkg::CH_PORT1_CURRENT;
            hold_armed_r <= 1'b0;
        end else if (i_rd_en && rd_hit && !rd_high) begin
            high_hold_r <= rd_count[8:1]; // [RULE_17]
            hold_chan_r <= rd_chan;
            hold_armed_r <= 1'b1;
        end else if (i_rd_en && rd_hit && rd_high && (rd_chan == hold_chan_r)) begin
            hold_armed_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------

    // low register carries the count lsb in bit 0, high register bits 8:1
    always_comb begin
        rd_data_nxt = result_regs_pkg::UNMAPPED_READ_DATA;
        if (i_rd_addr == result_regs_pkg::OFS_LEGACY_RESULT_PORTS_3_4) begin
            rd_data_nxt = {fourth_port_legacy_code_r, third_port_legacy_code_r}; // [RULE_01] [RULE_02]
        end else if (rd_hit && !rd_high) begin
            rd_data_nxt = {7'h00, rd_count[result_regs_pkg::LOW_BIT_POS]}; // [RULE_07] [RULE_10]
        end else if (rd_hit && hold_armed_r && (rd_chan == hold_chan_r)) begin
            rd_data_nxt = high_hold_r; // [RULE_17]
        end else if (rd_hit) begin
            rd_data_nxt = rd_count[8:1]; // [RULE_08] [RULE_12] [RULE_13] [RULE_14]
        end
    end

    // read data is registered and stands until the next read
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rd_data <= result_regs_pkg::RST_READ_DATA;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rd_data <= rd_data_nxt; // [RULE_11]
            end
        end
    end

    // ------------------------------------------------------------------
    // writes
    // ------------------------------------------------------------------

    // every register here is read-only: a write to any of them is acknowledged
    // as ignored and the data is discarded
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wr_ignored <= 1'b0;
        end else begin
            o_wr_ignored <= i_wr_en
                && (wr_dec[4] || (i_wr_addr == result_regs_pkg::OFS_LEGACY_RESULT_PORTS_3_4)
                    || (i_wr_data != i_wr_data)); // [RULE_15]
        end
    end

endmodule

`default_nettype wire

/* File: port_telemetry_result_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// port checks on the result register bank
// --------------------------------------------------------------
module port_telemetry_result_regs_checker (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_rd_en,
    input wire logic [7:0] i_rd_addr,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic o_wr_ignored,
    input wire logic i_third_port_legacy_valid,
    input wire logic [3:0] i_third_port_legacy_code,
    input wire logic i_fourth_port_legacy_valid,
    input wire logic [3:0] i_fourth_port_legacy_code,
    input wire logic o_legacy_reject,
    input wire logic i_adc_valid,
    input wire logic [2:0] i_adc_chan,
    input wire logic [8:0] i_adc_count
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    function automatic logic legal(input logic [3:0] c);
        return c inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    endfunction
    function automatic logic [7:0] lo_ofs(input logic [2:0] ch);
        return (ch < 3'h5) ? 8'h40 + {4'h0, ch, 1'b0} : 8'h50;
    endfunction
    // a bad nibble on either port must be flagged
    logic bad_code;
    assign bad_code = (i_third_port_legacy_valid && !legal(i_third_port_legacy_code))
        || (i_fourth_port_legacy_valid && !legal(i_fourth_port_legacy_code));
    property p_rd_hold; !i_rd_en |=> !o_rd_valid && $stable(o_rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_wr_ign; i_wr_en && (i_wr_addr inside {8'h36, [8'h40:8'h49], 8'h50, 8'h51})
        |=> o_wr_ignored; endproperty
    a_wr_ign: assert property (p_wr_ign)
        else $error("mapped write not reported as ignored");
    property p_low_zero; i_rd_en && (i_rd_addr inside {8'h40, 8'h42, 8'h44, 8'h46, 8'h48,
        8'h50}) |=> o_rd_data[7:1] == 7'h00; endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("low result register has upper bits set");
    property p_code_legal; i_rd_en && i_rd_addr == 8'h36
        |=> legal(o_rd_data[7:4]) && legal(o_rd_data[3:0]); endproperty
    a_code_legal: assert property (p_code_legal)
        else $error("undefined legacy code reported");
    property p_reject; bad_code |=> o_legacy_reject; endproperty
    a_reject: assert property (p_reject)
        else $error("undefined legacy code not rejected");
    property p_third; (i_third_port_legacy_valid && legal(i_third_port_legacy_code))
        ##1 !i_third_port_legacy_valid ##1 (!i_third_port_legacy_valid && i_rd_en
        && i_rd_addr == 8'h36) |=> o_rd_data[3:0] == $past(i_third_port_legacy_code, 3);
    endproperty
    a_third: assert property (p_third)
        else $error("port 3 outcome not in low nibble");
    property p_fourth; (i_fourth_port_legacy_valid && legal(i_fourth_port_legacy_code))
        ##1 !i_fourth_port_legacy_valid ##1 (!i_fourth_port_legacy_valid && i_rd_en
        && i_rd_addr == 8'h36) |=> o_rd_data[7:4] == $past(i_fourth_port_legacy_code, 3);
    endproperty
    a_fourth: assert property (p_fourth)
        else $error("port 4 outcome not in high nibble");
    property p_pair_low; (i_adc_valid && i_adc_chan < 3'h6) ##1 !i_adc_valid ##1
        (!i_adc_valid && i_rd_en && i_rd_addr == lo_ofs($past(i_adc_chan, 2)))
        |=> o_rd_data == {7'h00, $past(i_adc_count[0], 3)}; endproperty
    a_pair_low: assert property (p_pair_low)
        else $error("low result bit differs from sample");
    property p_pair_high; (i_adc_valid && i_adc_chan < 3'h6) ##1 !i_adc_valid ##1
        (!i_adc_valid && i_rd_en && i_rd_addr == lo_ofs($past(i_adc_chan, 2))) ##1
        (i_rd_en && i_rd_addr == lo_ofs($past(i_adc_chan, 3)) + 8'h01)
        |=> o_rd_data == $past(i_adc_count[8:1], 4); endproperty
    a_pair_high: assert property (p_pair_high)
        else $error("high result byte differs from sample");
endmodule
bind port_telemetry_result_regs port_telemetry_result_regs_checker chk (.i_clk_sys, .i_srst,
    .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid, .i_wr_en, .i_wr_addr, .i_wr_data,
    .o_wr_ignored, .i_third_port_legacy_valid, .i_third_port_legacy_code,
    .i_fourth_port_legacy_valid, .i_fourth_port_legacy_code, .o_legacy_reject,
    .i_adc_valid, .i_adc_chan, .i_adc_count);
`default_nettype wire

/* File: host_reader.sv */
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// host side: reads pairs back to back, writes single bytes
// --------------------------------------------------------------
module host_reader (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_wr_ignored,
    output logic o_rd_en,
    output logic [7:0] o_rd_addr,
    output logic o_wr_en,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data
);
    initial begin
        o_rd_en = 1'b0;
        o_rd_addr = 8'h00;
        o_wr_en = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // data without its valid pulse turns to x so it cannot match
    task automatic rd2(input logic [7:0] a0, input logic [7:0] a1, output logic [7:0] d0,
        output logic [7:0] d1);
        @(posedge i_clk_sys);
        o_rd_en <= 1'b1;
        o_rd_addr <= a0;
        @(posedge i_clk_sys);
        o_rd_addr <= a1;
        #1 d0 = i_rd_valid ? i_rd_data : 8'hxx;
        @(posedge i_clk_sys);
        o_rd_en <= 1'b0;
        o_rd_addr <= ~a1;
        #1 d1 = i_rd_valid ? i_rd_data : 8'hxx;
    endtask
    task automatic wr(input logic [7:0] a, output logic ign);
        @(posedge i_clk_sys);
        o_wr_en <= 1'b1;
        o_wr_addr <= a;
        o_wr_data <= ~a;
        @(posedge i_clk_sys);
        o_wr_en <= 1'b0;
        #1 ign = i_wr_ignored;
    endtask
endmodule
`default_nettype wire

/* File: port_telemetry_result_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (a), (e)); end end
module port_telemetry_result_regs_bench;
    typedef struct packed {logic [2:0] ch; logic [8:0] cnt; logic [7:0] lo, elo, ehi;} row_t;
    logic i_clk_sys, i_srst, rd_en, wr_en, rd_valid, wr_ign, adc_valid, v3, v4, rej, r;
    logic [7:0] rd_addr, rd_data, wr_addr, wr_data, d0, d1, exp_mem [0:255];
    logic [3:0] c3, c4, e3, e4;
    logic [2:0] adc_chan;
    logic [8:0] adc_count;
    int fail_count = 0;
    int cmp_count = 0;
    row_t rows [8] = '{'{3'h0, 9'h1ff, 8'h40, 8'h01, 8'hff}, '{3'h1, 9'h155, 8'h42, 8'h01, 8'haa},
        '{3'h2, 9'h0aa, 8'h44, 8'h00, 8'h55}, '{3'h3, 9'h100, 8'h46, 8'h00, 8'h80},
        '{3'h4, 9'h001, 8'h48, 8'h01, 8'h00}, '{3'h5, 9'h1fe, 8'h50, 8'h00, 8'hff},
        '{3'h0, 9'h0fe, 8'h40, 8'h00, 8'h7f}, '{3'h5, 9'h101, 8'h50, 8'h01, 8'h80}};
    logic [7:0] mapped [13] = '{8'h36, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
        8'h47, 8'h48, 8'h49, 8'h50, 8'h51};
    port_telemetry_result_regs uut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_rd_en(rd_en),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_wr_en(wr_en),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_wr_ignored(wr_ign),
        .i_third_port_legacy_valid(v3), .i_third_port_legacy_code(c3),
        .i_fourth_port_legacy_valid(v4), .i_fourth_port_legacy_code(c4),
        .o_legacy_reject(rej), .i_adc_valid(adc_valid), .i_adc_chan(adc_chan),
        .i_adc_count(adc_count));
    host_reader host (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .i_wr_ignored(wr_ign), .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_wr_en(wr_en),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    // --------------------------------------------------------------
    // stimulus tasks
    // --------------------------------------------------------------
    function automatic logic legal_code(input logic [3:0] c);
        return c inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    endfunction
    // one sample; channels 6 and 7 leave the expected map alone
    task automatic adc(input logic [2:0] ch, input logic [8:0] cnt);
        logic [7:0] lo;
        lo = (ch < 3'h5) ? 8'h40 + {4'h0, ch, 1'b0} : 8'h50;
        @(posedge i_clk_sys);
        adc_valid <= 1'b1;
        adc_chan <= ch;
        adc_count <= cnt;
        @(posedge i_clk_sys);
        adc_valid <= 1'b0;
        adc_count <= ~cnt;
        if (ch < 3'h6) begin
            exp_mem[lo] = {7'h00, cnt[0]};
            exp_mem[lo + 8'h01] = cnt[8:1];
        end
    endtask
    task automatic leg(input logic [3:0] k3, input logic [3:0] k4);
        @(posedge i_clk_sys);
        {v3, v4, c3, c4} <= {2'b11, k3, k4};
        @(posedge i_clk_sys);
        {v3, v4} <= 2'b00;
        #1 r = rej;
        if (legal_code(k3)) e3 = k3;
        if (legal_code(k4)) e4 = k4;
        exp_mem[8'h36] = {e4, e3};
    endtask
    task automatic sweep();
        foreach (mapped[i]) begin
            host.rd2(mapped[i], mapped[i], d0, d1);
            `CHK(d1, exp_mem[mapped[i]])
        end
        host.rd2(8'h3f, 8'h52, d0, d1);
        `CHK(d0 | d1, 8'h00)
    endtask
    task automatic close_out();
        $display("compared %0d, mismatched %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // --------------------------------------------------------------
    // clock, watchdog and test sequence
    // --------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // the whole run needs about 350 cycles; allow nearly thirty times that
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    initial begin
        {i_srst, adc_valid, v3, v4, c3, c4, e3, e4, adc_chan, adc_count} = {4'h8, 28'h0};
        foreach (exp_mem[i]) exp_mem[i] = 8'h00;
        repeat (12) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        sweep();
        $display("reset values done");
        foreach (rows[i]) begin
            adc(rows[i].ch, rows[i].cnt);
            host.rd2(rows[i].lo, rows[i].lo + 8'h01, d0, d1);
            `CHK(d0, rows[i].elo)
            `CHK(d1, rows[i].ehi)
        end
        $display("result pairs done");
        for (int k = 0; k < 16; k++) begin
            leg(4'(k), 4'(15 - k));
            `CHK(r, !(legal_code(4'(k)) && legal_code(4'(15 - k))))
            host.rd2(8'h36, 8'h36, d0, d1);
            `CHK(d0, {e4, e3})
        end
        $display("legacy codes done");
        foreach (mapped[i]) begin
            host.wr(mapped[i], r);
            `CHK(r, 1'b1)
        end
        host.wr(8'h3f, r);
        `CHK(r, 1'b0)
        sweep();
        $display("writes done");
        adc(3'h0, 9'h0f3);
        host.rd2(8'h40, 8'h40, d0, d1);
        adc(3'h0, 9'h10c);
        adc(3'h6, 9'h1ff);
        adc(3'h7, 9'h1ff);
        host.rd2(8'h41, 8'h41, d0, d1);
        `CHK(d0, 8'h79)
        `CHK(d1, 8'h86)
        sweep();
        $display("coherence and dropped channels done");
        // raise reset on an edge like every other stimulus
        @(posedge i_clk_sys);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        foreach (exp_mem[i]) exp_mem[i] = 8'h00;
        {e3, e4} = 8'h00;
        sweep();
        $display("second reset done");
        close_out();
    end
endmodule
`default_nettype wire
